// ### include/label_access_consts.svh
// Constants for the partition label register access control block
`ifndef LABEL_ACCESS_CONSTS_SVH
`define LABEL_ACCESS_CONSTS_SVH
`define OP0_LABEL        2'h3
`define CRN_LABEL        4'ha
`define CRM_LABEL        4'h5
`define OP2_LABEL        3'h0
`define OP1_EL1          3'h0
`define OP1_EL2          3'h4
`define OP1_EL3          3'h6
`define EC_SYSREG        6'h18
`define DEFER_EL1_OFFSET 12'h900
`define BIT_ENABLE       63
`define BIT_TRAPLOW      62
`define BIT_SDEF         61
`define BIT_NSFORCE      60
`define BIT_TRAPEL1      48
`define ENABLE_RESET     1'h0
`define TRAPLOW_RESET    1'h1
`define TRAPEL1_RESET    1'h1
`endif

// ### include/label_access_pkg.sv
// Types for the partition label register access control block
package label_access_pkg;
  typedef enum logic [1:0] {
    OUT_DONE  = 2'h0,
    OUT_UNDEF = 2'h1,
    OUT_TRAP2 = 2'h2,
    OUT_TRAP3 = 2'h3
  } outcome_t;

  typedef enum logic [1:0] {
    TGT_NONE  = 2'h0,
    TGT_EL1   = 2'h1,
    TGT_EL2   = 2'h2,
    TGT_DEFER = 2'h3
  } target_t;

  // One system instruction request from the core
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  el;
    logic [1:0]  op0;
    logic [2:0]  op1;
    logic [3:0]  crn;
    logic [3:0]  crm;
    logic [2:0]  op2;
    logic [63:0] wdata;
  } sysreq_t;

  // Hypervisor configuration levels seen by the block
  typedef struct packed {
    logic el2_enabled;
    logic el3_present;
    logic nv2;
    logic nv1;
    logic nv;
    logic e2h;
    logic secure;
    logic [1:0] cur_el;
  } ctx_t;

  // Answer for one request
  typedef struct packed {
    logic        valid;
    outcome_t    outcome;
    target_t     target;
    logic [5:0]  ec;
    logic [11:0] defer_off;
    logic [63:0] rdata;
  } sysresp_t;

  // Labels driven to the memory system
  typedef struct packed {
    logic        use_default;
    logic [1:0]  src_el;
    logic        force_pid0;
    logic        ns_bit;
  } label_t;

  typedef struct packed {
    logic [63:0] el1_q;
    logic [63:0] el2_q;
    logic [59:0] el3_low_q;
    logic        enable_q;
    logic        traplow_q;
    logic        sdef_q;
    logic        nsforce_q;
    sysresp_t    resp_q;
    label_t      label_q;
  } state_t;
endpackage

// ### rtl/label_access_ctrl.sv
// Access control and EL3 configuration for partition label system registers
`timescale 1ns/10ps
`include "label_access_consts.svh"
module partition_label_reg_access_ctrl
  import label_access_pkg::*;
#(
  parameter logic FEATURE_PRESENT = 1'b1,
  parameter logic SDEF_PRESENT    = 1'b1,
  parameter logic NSF_PRESENT     = 1'b1,
  parameter logic NS_ZERO_OK      = 1'b1
) (
  input  wire logic     clk,
  input  wire logic     rst_n,
  input  wire sysreq_t  req,
  input  wire ctx_t     ctx,
  output sysresp_t      resp,
  output label_t        label_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Match the shared label register encoding with a given op1
  function automatic logic enc_hit(input sysreq_t r, input logic [2:0] op1);
    enc_hit = (r.op0 == `OP0_LABEL) && (r.crn == `CRN_LABEL) &&
              (r.crm == `CRM_LABEL) && (r.op2 == `OP2_LABEL) && (r.op1 == op1);
  endfunction

  // Compose bit 63 from the enable over the stored low field
  function automatic logic [63:0] with_top(input logic [63:0] v, input logic en);
    with_top = {en, v[62:0]};
  endfunction

  state_t s_q;
  state_t s_d;
  logic   trap3;
  logic   nsf_read;

  // The forced EL3 trap applies to accesses from levels 1 and 2; level 0 stays undefined
  assign trap3    = ctx.el3_present && s_q.traplow_q;
  assign nsf_read = NS_ZERO_OK ? s_q.nsforce_q : 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.resp_q = '0;
    s_d.resp_q.ec = `EC_SYSREG;
    if (req.valid) begin
      s_d.resp_q.valid = 1'b1;
      s_d.resp_q.outcome = OUT_UNDEF;
      if (!FEATURE_PRESENT) begin
        s_d.resp_q.outcome = OUT_UNDEF;
      end else if (enc_hit(req, `OP1_EL2)) begin
        if (req.el == 2'd0) begin
          s_d.resp_q.outcome = OUT_UNDEF;
        end else if (req.el == 2'd1) begin
          if (ctx.el2_enabled && ctx.nv) begin
            s_d.resp_q.outcome = trap3 ? OUT_TRAP3 : OUT_TRAP2;
          end else begin
            s_d.resp_q.outcome = OUT_UNDEF;
          end
        end else if (req.el == 2'd2 && trap3) begin
          s_d.resp_q.outcome = OUT_TRAP3;
        end else begin
          s_d.resp_q.outcome = OUT_DONE;
          s_d.resp_q.target  = TGT_EL2;
        end
      end else if (enc_hit(req, `OP1_EL1)) begin
        if (req.el == 2'd0) begin
          s_d.resp_q.outcome = OUT_UNDEF;
        end else if (req.el == 2'd1) begin
          if (trap3) begin
            s_d.resp_q.outcome = OUT_TRAP3;
          end else if (ctx.el2_enabled && s_q.el2_q[`BIT_TRAPEL1]) begin
            s_d.resp_q.outcome = OUT_TRAP2;
          end else if (ctx.el2_enabled && ctx.nv2 && ctx.nv1 && ctx.nv) begin
            s_d.resp_q.outcome   = OUT_DONE;
            s_d.resp_q.target    = TGT_DEFER;
            s_d.resp_q.defer_off = `DEFER_EL1_OFFSET;
          end else begin
            s_d.resp_q.outcome = OUT_DONE;
            s_d.resp_q.target  = TGT_EL1;
          end
        end else if (req.el == 2'd2) begin
          if (trap3) begin
            s_d.resp_q.outcome = OUT_TRAP3;
          end else begin
            s_d.resp_q.outcome = OUT_DONE;
            s_d.resp_q.target  = ctx.e2h ? TGT_EL2 : TGT_EL1;
          end
        end else begin
          s_d.resp_q.outcome = OUT_DONE;
          s_d.resp_q.target  = TGT_EL1;
        end
      end else if (enc_hit(req, `OP1_EL3)) begin
        if (req.el == 2'd3) begin
          s_d.resp_q.outcome = OUT_DONE;
          s_d.resp_q.target  = TGT_NONE;
          if (req.write) begin
            s_d.enable_q  = req.wdata[`BIT_ENABLE];
            s_d.traplow_q = req.wdata[`BIT_TRAPLOW];
            s_d.sdef_q    = SDEF_PRESENT & req.wdata[`BIT_SDEF];
            s_d.nsforce_q = NSF_PRESENT & NS_ZERO_OK & req.wdata[`BIT_NSFORCE];
          end else begin
            s_d.resp_q.rdata = {s_q.enable_q, s_q.traplow_q,
                                SDEF_PRESENT & s_q.sdef_q,
                                NSF_PRESENT & nsf_read, 60'h0};
          end
        end
      end
      // Completed EL1 and EL2 targets read or write the live storage directly
      if (s_d.resp_q.outcome == OUT_DONE && s_d.resp_q.target == TGT_EL2) begin
        if (req.write) begin
          s_d.el2_q    = {1'b0, 4'h0, req.wdata[58:0]};
          if (!ctx.el3_present) begin
            s_d.enable_q = req.wdata[`BIT_ENABLE];
          end
        end else begin
          s_d.resp_q.rdata = with_top(s_q.el2_q, s_q.enable_q);
        end
      end else if (s_d.resp_q.outcome == OUT_DONE && s_d.resp_q.target == TGT_EL1) begin
        if (req.write) begin
          s_d.el1_q = {1'b0, req.wdata[62:0]};
        end else begin
          s_d.resp_q.rdata = with_top(s_q.el1_q, s_q.enable_q);
        end
      end
    end
    // Label source follows the current level and global enable
    s_d.label_q.use_default = !s_q.enable_q;
    s_d.label_q.src_el      = ctx.cur_el;
    s_d.label_q.force_pid0  = SDEF_PRESENT && ctx.secure && s_q.sdef_q;
    s_d.label_q.ns_bit      = ctx.secure ? (NSF_PRESENT && nsf_read) : 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q           <= '0;
      s_q.enable_q  <= `ENABLE_RESET;
      s_q.traplow_q <= `TRAPLOW_RESET;
      s_q.el2_q[`BIT_TRAPEL1] <= `TRAPEL1_RESET;
      s_q.label_q.use_default <= 1'b1;
      s_q.label_q.ns_bit <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign resp      = s_q.resp_q;
  assign label_out = s_q.label_q;

endmodule // partition_label_reg_access_ctrl

// ### testbench/label_access_chk.sv
// Assertion checker for the label register access block
`timescale 1ns/10ps
module label_access_chk
  import label_access_pkg::*;
(
  input wire logic     clk,
  input wire logic     rst_n,
  input wire sysreq_t  req,
  input wire ctx_t     ctx,
  input wire sysresp_t resp,
  input wire label_t   label_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Encoding hits one of the three label registers
  wire logic lbl = req.op0 == 2'h3 && req.crn == 4'ha && req.crm == 4'h5 && req.op2 == 3'h0
                   && req.op1 inside {3'h0, 3'h4, 3'h6};
  ////////////////////////////////////////////////////////////
  // Answer timing and outcomes
  resp_latency_a: assert property (req.valid |=> resp.valid)
    else $error("missing answer");
  resp_origin_a: assert property (resp.valid |-> $past(req.valid))
    else $error("answer without request");
  el0_undef_a: assert property (req.valid && req.el == 2'h0 |=> resp.outcome == OUT_UNDEF)
    else $error("level 0 access defined");
  el3_done_a: assert property (
    req.valid && lbl && req.el == 2'h3 |=> resp.outcome == OUT_DONE)
    else $error("level 3 access not done");
  low_el3reg_a: assert property (req.valid && req.op1 == 3'h6 && req.el != 2'h3
    |=> resp.outcome == OUT_UNDEF)
    else $error("low access to level 3 register");
  trap_class_a: assert property (resp.valid |-> resp.ec == 6'h18)
    else $error("wrong exception class");
  defer_off_a: assert property (resp.valid && resp.target == TGT_DEFER
    |-> resp.defer_off == 12'h900)
    else $error("wrong deferred offset");
  ns_outside_a: assert property (!ctx.secure |=> label_out.ns_bit)
    else $error("nonsecure bit low outside secure");
  // Main scenarios reached
  cover property (resp.valid && resp.target == TGT_DEFER);
  cover property (resp.valid && resp.outcome == OUT_TRAP2);
  cover property (label_out.force_pid0);
endmodule // label_access_chk
bind partition_label_reg_access_ctrl label_access_chk u_chk (.clk(clk), .rst_n(rst_n),
  .req(req), .ctx(ctx), .resp(resp), .label_out(label_out));

// ### testbench/core_model.sv
// Core model that issues system register requests with their level context
`timescale 1ns/10ps
module core_model
  import label_access_pkg::*;
(
  input  wire logic    clk,
  input  wire sysreq_t cmd,
  input  wire ctx_t    cmd_ctx,
  output sysreq_t      req,
  output ctx_t         ctx
);
  // Launch after the edge; idle fields show inverted data, never a stale request
  always_ff @(posedge clk) begin
    req <= cmd.valid ? cmd : {1'b0, ~cmd[$bits(sysreq_t)-2:0]};
    ctx <= cmd_ctx;
  end
endmodule // core_model

// ### testbench/partition_label_reg_access_ctrl_test.sv
// Self-checking bench for the label register access block
`timescale 1ns/10ps
module partition_label_reg_access_ctrl_test
  import label_access_pkg::*;
;
  localparam logic [6:0]  E  = 7'h60;
  localparam logic [63:0] EN = 64'h8000_0000_0000_0000;
  logic     clk = 1'b0;
  logic     rst_n = 1'b0;
  sysreq_t  cmd = '0;
  ctx_t     cmd_ctx = '0;
  sysreq_t  req;
  ctx_t     ctx;
  sysresp_t resp;
  label_t   label_out;
  int       errors = 0;
  int       compares = 0;
  always #10 clk = ~clk;
  core_model u_core (.clk(clk), .cmd(cmd), .cmd_ctx(cmd_ctx), .req(req), .ctx(ctx));
  partition_label_reg_access_ctrl u_dut (.clk(clk), .rst_n(rst_n), .req(req), .ctx(ctx),
    .resp(resp), .label_out(label_out));
  ////////////////////////////////////////////////////////////
  // Compare and verdict
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // One request through the core model, then a bounded wait for its answer
  task automatic acc(input logic [6:0] c, input logic [1:0] el, input logic [2:0] op1,
                     input logic wr, input logic [63:0] wd, input outcome_t eo,
                     input target_t et, input logic [63:0] er);
    int n;
    @(posedge clk);
    cmd <= '{1'b1, wr, el, 2'h3, op1, 4'ha, 4'h5, 3'h0, wd};
    cmd_ctx <= {c, el};
    @(posedge clk);
    cmd.valid <= 1'b0;
    for (n = 0; n < 4 && resp.valid !== 1'b1; n++) begin
      @(negedge clk);
    end
    if (resp.valid !== 1'b1) begin
      errors++;
      wrap_up();
    end
    chk(64'(resp.outcome), 64'(eo));
    if (eo == OUT_DONE) chk(64'(resp.target), 64'(et));
    if (eo == OUT_DONE && et != TGT_DEFER) chk(resp.rdata, er);
  endtask
  // Label outputs one cycle on: use_default, src_el, force_pid0, ns_bit
  task automatic lab(input logic [4:0] exp);
    @(negedge clk);
    chk(64'({label_out.use_default, label_out.src_el, label_out.force_pid0,
             label_out.ns_bit}), 64'(exp));
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    lab(5'h11);
    acc(E, 2'h3, 3'h6, 1'b0, '0, OUT_DONE, TGT_NONE, 64'h4000_0000_0000_0000);
    acc(E, 2'h2, 3'h4, 1'b0, '0, OUT_TRAP3, TGT_NONE, '0);
    acc(E | 7'h04, 2'h1, 3'h4, 1'b0, '0, OUT_TRAP3, TGT_NONE, '0);
    acc(E, 2'h0, 3'h4, 1'b0, '0, OUT_UNDEF, TGT_NONE, '0);
    acc(E, 2'h2, 3'h6, 1'b0, '0, OUT_UNDEF, TGT_NONE, '0);
    acc(E, 2'h3, 3'h6, 1'b1, EN, OUT_DONE, TGT_NONE, '0);
    lab(5'h0d);
    acc(E | 7'h04, 2'h1, 3'h4, 1'b0, '0, OUT_TRAP2, TGT_NONE, '0);
    acc(E, 2'h2, 3'h4, 1'b1, '0, OUT_DONE, TGT_EL2, '0);
    acc(E, 2'h2, 3'h4, 1'b0, '0, OUT_DONE, TGT_EL2, EN);
    acc(E | 7'h1c, 2'h1, 3'h0, 1'b0, '0, OUT_DONE, TGT_DEFER, '0);
    acc(E, 2'h1, 3'h0, 1'b0, '0, OUT_DONE, TGT_EL1, EN);
    acc(E | 7'h02, 2'h2, 3'h0, 1'b0, '0, OUT_DONE, TGT_EL2, EN);
    acc(E, 2'h2, 3'h4, 1'b1, 64'h0001_0000_0000_0000, OUT_DONE, TGT_EL2, '0);
    acc(E, 2'h1, 3'h0, 1'b0, '0, OUT_TRAP2, TGT_NONE, '0);
    acc(E | 7'h01, 2'h3, 3'h6, 1'b1, 64'h9000_0000_0000_0000, OUT_DONE, TGT_NONE, '0);
    lab(5'h0d);
    acc(E | 7'h01, 2'h3, 3'h6, 1'b1, 64'ha000_0000_0000_0000, OUT_DONE, TGT_NONE, '0);
    lab(5'h0e);
    wrap_up();
  end
endmodule // partition_label_reg_access_ctrl_test
